//--- plm_pkg.sv
package plm_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned STAB_MS = 330;
  localparam int unsigned STAB_CYCLES = STAB_MS * (CLK_HZ / 1000);
  localparam int unsigned PD_RESET_CYCLES = 16;
  localparam int unsigned LEN_W = 8;
  localparam int unsigned PULSE_CYCLES = 4;
  localparam int unsigned LISTEN_CYCLES = 255;
  typedef enum logic [1:0] {
    LM_DOWN,
    LM_STAB,
    LM_READY,
    LM_UP
  } plm_link_type;
  typedef enum logic [1:0] {
    TD_IDLE,
    TD_PULSE,
    TD_LISTEN,
    TD_DONE
  } plm_tdr_type;
endpackage : plm_pkg

//--- plm_tdr_if.sv
`timescale 1ns/1ps
// link monitor and reflectometry engine exchange
interface plm_tdr_if;
  logic test_busy;
  modport engine (output test_busy);
  modport monitor (input test_busy);
endinterface : plm_tdr_if

//--- plm_link_mon.sv
`timescale 1ns/1ps
// 100 Mbps link integrity monitor
module plm_link_mon
  import plm_pkg::*;
#(
  parameter int unsigned STAB_CNT = STAB_CYCLES
) (
  input wire logic clk, // core clock
  input wire logic rst_n, // sync reset
  input wire logic data_valid, // synchronised line valid
  input wire logic aneg_en, // negotiation enabled
  input wire logic aneg_done, // negotiation grants link
  plm_tdr_if.monitor tif, // test hand-off
  output logic link_ok // 100 Mbps link result
);
  plm_link_type state_ff;
  plm_link_type nxt_state;
  logic [31:0] cnt_ff;
  logic stab_done;

  assign stab_done = (cnt_ff >= STAB_CNT - 1);
  assign link_ok = (state_ff == LM_UP);

  // next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      LM_DOWN: if (data_valid) nxt_state = LM_STAB;
      LM_STAB: begin
        if (stab_done) begin
          if (aneg_en) nxt_state = LM_READY;
          else nxt_state = LM_UP;
        end
      end
      LM_READY: if (aneg_done) nxt_state = LM_UP;
      LM_UP: nxt_state = LM_UP;
      default: nxt_state = LM_DOWN;
    endcase
    // loss of valid or running test wins from any state
    if (!data_valid || tif.test_busy) nxt_state = LM_DOWN;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) state_ff <= LM_DOWN;
    else state_ff <= nxt_state;
  end

  // stabilization timer only counts while waiting
  always_ff @(posedge clk) begin
    if (!rst_n || state_ff != LM_STAB || !data_valid) cnt_ff <= 32'h0000_0000;
    else if (!stab_done) cnt_ff <= cnt_ff + 32'h0000_0001;
  end
endmodule : plm_link_mon

//--- plm_tdr_eng.sv
`timescale 1ns/1ps
// reflectometry pulse and timing engine
module plm_tdr_eng
  import plm_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rst_n, // sync reset
  input wire logic reg_rst_n, // hardware reset of the result register
  input wire logic start, // enable bit set
  input wire logic echo, // synchronised reflection seen
  plm_tdr_if.engine tif, // test hand-off
  output logic pulse_on, // drive pulse
  output logic done, // result valid
  output logic [LEN_W-1:0] length // electrical length
);
  plm_tdr_type st_ff;
  logic [LEN_W-1:0] cnt_ff;
  logic [LEN_W-1:0] len_ff;
  logic hit;

  assign tif.test_busy = (st_ff == TD_PULSE) || (st_ff == TD_LISTEN);
  assign pulse_on = (st_ff == TD_PULSE);
  assign done = (st_ff == TD_DONE);
  assign length = len_ff;
  // saturated count means no reflection: matched line
  assign hit = (st_ff == TD_LISTEN) && (echo || cnt_ff == LEN_W'(LISTEN_CYCLES));

  // sequencer: pulse, then time the echo
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= TD_IDLE;
      cnt_ff <= '0;
    end else begin
      case (st_ff)
        TD_IDLE: if (start) begin
          st_ff <= TD_PULSE;
          cnt_ff <= '0;
        end
        TD_PULSE: begin
          if (cnt_ff == LEN_W'(PULSE_CYCLES - 1)) begin
            st_ff <= TD_LISTEN;
            cnt_ff <= '0;
          end else cnt_ff <= cnt_ff + 1'b1;
        end
        TD_LISTEN: begin
          if (hit) st_ff <= TD_DONE;
          else cnt_ff <= cnt_ff + 1'b1;
        end
        TD_DONE: if (!start) st_ff <= TD_IDLE;
        default: st_ff <= TD_IDLE;
      endcase
    end
  end

  // result is register content: a power-down wake must leave it alone
  always_ff @(posedge clk) begin
    if (!reg_rst_n) len_ff <= '0;
    else if (rst_n && hit) len_ff <= cnt_ff;
  end
endmodule : plm_tdr_eng

//--- plm_top.sv
`timescale 1ns/1ps
// PHY port link monitor, power-down reset and reflectometry control
module plm_top
  import plm_pkg::*;
#(
  parameter int unsigned STAB_CNT = STAB_CYCLES
) (
  input wire logic CLK, // core clock
  input wire logic RESET_N, // sync reset
  input wire logic POWER_DOWN, // power-down request level
  input wire logic DATA_VALID, // equalizer signal valid
  input wire logic ANEG_EN, // negotiation enabled
  input wire logic ANEG_DONE, // negotiation grants link
  input wire logic SPEED_10, // 10BASE-T selected
  input wire logic LINK_10, // 10BASE-T receiver link
  input wire logic FX_MODE, // fiber mode
  input wire logic TDR_EN, // reflectometry enable bit
  input wire logic CROSSOVER_STATE_SELECT, // 1 = crossover pair
  input wire logic ECHO, // reflection detector
  output logic PHY_LOGIC_RST, // internal reset pulse
  output logic LINK_STATUS, // status bit and LED
  output logic TXRX_ENABLE, // datapath enable
  output logic PULSE_TX_PAIR, // pulse on transmit pair
  output logic PULSE_RX_PAIR, // pulse on receive pair
  output logic TDR_DONE, // test finished
  output logic [LEN_W-1:0] CHANNEL_LENGTH // electrical length
);
  logic [1:0] valid_sync_ff;
  logic [1:0] echo_sync_ff;
  logic [1:0] pd_sync_ff;
  logic pd_prev_ff;
  logic [4:0] pdr_cnt_ff;
  logic core_rst_n;
  logic link100;
  logic pulse;
  logic done;
  logic [LEN_W-1:0] len;
  plm_tdr_if tif ();

  // pin synchronisers
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      valid_sync_ff <= 2'h0;
      echo_sync_ff <= 2'h0;
      pd_sync_ff <= 2'h0;
    end else begin
      valid_sync_ff <= {valid_sync_ff[0], DATA_VALID};
      echo_sync_ff <= {echo_sync_ff[0], ECHO};
      pd_sync_ff <= {pd_sync_ff[0], POWER_DOWN};
    end
  end

  // reset pulse on exit from power-down; registers live elsewhere and are untouched
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      pd_prev_ff <= 1'b0;
      pdr_cnt_ff <= 5'h00;
    end else begin
      pd_prev_ff <= pd_sync_ff[1];
      if (pd_prev_ff && !pd_sync_ff[1]) pdr_cnt_ff <= 5'(PD_RESET_CYCLES);
      else if (pdr_cnt_ff != 5'h00) pdr_cnt_ff <= pdr_cnt_ff - 5'h01;
    end
  end
  assign PHY_LOGIC_RST = (pdr_cnt_ff != 5'h00);
  assign core_rst_n = RESET_N && !PHY_LOGIC_RST;

  plm_link_mon #(.STAB_CNT(STAB_CNT)) u_mon (
    .clk(CLK),
    .rst_n(core_rst_n),
    .data_valid(valid_sync_ff[1]),
    .aneg_en(ANEG_EN),
    .aneg_done(ANEG_DONE),
    .tif(tif),
    .link_ok(link100)
  );

  plm_tdr_eng u_tdr (
    .clk(CLK),
    .rst_n(core_rst_n),
    .reg_rst_n(RESET_N),
    .start(TDR_EN && !FX_MODE),
    .echo(echo_sync_ff[1]),
    .tif(tif),
    .pulse_on(pulse),
    .done(done),
    .length(len)
  );

  // speed mux for status and LED; test forces link down
  assign LINK_STATUS = tif.test_busy ? 1'b0 : (SPEED_10 ? LINK_10 : link100);
  assign TXRX_ENABLE = LINK_STATUS;
  assign PULSE_TX_PAIR = pulse && !CROSSOVER_STATE_SELECT;
  assign PULSE_RX_PAIR = pulse && CROSSOVER_STATE_SELECT;
  assign TDR_DONE = done;
  assign CHANNEL_LENGTH = len;
endmodule : plm_top

//--- plm_monitor.sv
`timescale 1ns/1ps
// port timing of link, power-down reset and cable test
module plm_monitor
  import plm_pkg::*;
#(
  parameter int unsigned STAB_CNT = STAB_CYCLES // settle count
) (
  input wire logic CLK, // core clock
  input wire logic RESET_N, // sync reset
  input wire logic POWER_DOWN, // power-down level
  input wire logic DATA_VALID, // line valid pin
  input wire logic ANEG_EN, // negotiation enabled
  input wire logic ANEG_DONE, // negotiation grant
  input wire logic SPEED_10, // 10BASE-T selected
  input wire logic LINK_10, // 10BASE-T link
  input wire logic FX_MODE, // fiber mode
  input wire logic TDR_EN, // test enable
  input wire logic CROSSOVER_STATE_SELECT, // pair select
  input wire logic PHY_LOGIC_RST, // wake reset
  input wire logic LINK_STATUS, // link status
  input wire logic PULSE_TX_PAIR, // transmit pair pulse
  input wire logic PULSE_RX_PAIR, // receive pair pulse
  input wire logic TDR_DONE // test finished
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  wire logic pul = PULSE_TX_PAIR || PULSE_RX_PAIR; // either pair driven
  // link, pulse and wake-reset outputs tied to their causes; exact pulse width, cycle windows for the delays
  speed_sel_a: assert property (SPEED_10 |-> LINK_STATUS == LINK_10)
    else $error("10M link not used");
  // valid run length in a counter: a deep history would stall the tools
  int unsigned valid_run;
  always_ff @(posedge CLK) begin
    if (!DATA_VALID) valid_run <= '0;
    else if (valid_run < STAB_CNT) valid_run <= valid_run + 1;
  end
  settle_wait_a: assert property ($rose(LINK_STATUS) && !SPEED_10 |->
    valid_run >= STAB_CNT && (ANEG_DONE || !ANEG_EN)) else $error("link up early");
  valid_drop_a: assert property ($fell(DATA_VALID) && !SPEED_10 |-> ##[0:3] !LINK_STATUS)
    else $error("link kept");
  test_down_a: assert property (pul && !SPEED_10 |-> !LINK_STATUS)
    else $error("link up in test");
  pair_sel_a: assert property (pul |-> PULSE_RX_PAIR == CROSSOVER_STATE_SELECT
    && PULSE_TX_PAIR != CROSSOVER_STATE_SELECT) else $error("wrong pair");
  pulse_len_a: assert property ($rose(pul) |-> pul [*4] ##1 !pul)
    else $error("pulse width");
  fiber_off_a: assert property (FX_MODE && TDR_EN |=> !pul)
    else $error("test in fiber");
  pd_exit_a: assert property ($fell(POWER_DOWN) |-> ##[1:5] PHY_LOGIC_RST)
    else $error("no reset on wake");
  cover property ($rose(LINK_STATUS) && ANEG_EN);
  cover property ($rose(TDR_DONE));
  cover property ($rose(PHY_LOGIC_RST));
endmodule : plm_monitor

bind plm_top plm_monitor #(.STAB_CNT(STAB_CNT)) mon (.*);

//--- plm_cable.sv
`timescale 1ns/1ps
// faulty cable: an open or short echoes dly cycles after the pulse ends
module plm_cable (
  input wire logic clk, // core clock
  input wire logic pulse, // pulse on either pair
  input wire logic [31:0] dly, // round trip, 0 = matched line
  output logic echo = 1'h0 // reflection
);
  int cnt = 0;
  // one-cycle echo, so a detector that only sees levels still times it
  always @(posedge clk) begin
    cnt <= pulse ? int'(dly) : (cnt > 0 ? cnt - 1 : 0);
    echo <= cnt == 1 && !pulse;
  end
endmodule : plm_cable

//--- plm_top_tb.sv
`timescale 1ns/1ps
module plm_top_tb;
  import plm_pkg::*;
  logic CLK = 0, RESET_N = 0, POWER_DOWN = 0, DATA_VALID = 0, ANEG_EN = 0, ANEG_DONE = 0;
  logic SPEED_10 = 0, LINK_10 = 0, FX_MODE = 0, TDR_EN = 0, CROSSOVER_STATE_SELECT = 0, ECHO;
  logic PHY_LOGIC_RST, LINK_STATUS, TXRX_ENABLE, PULSE_TX_PAIR, PULSE_RX_PAIR, TDR_DONE, seen;
  logic [LEN_W-1:0] CHANNEL_LENGTH, last_len;
  int fail_count = 0, n_compared = 0, dly = 0, d, last_d = 0;
  int notes[$];
  real far_m = 0.0;
  plm_top #(.STAB_CNT(20)) dut (.*);
  plm_cable cable (.clk(CLK), .pulse(PULSE_TX_PAIR | PULSE_RX_PAIR), .dly(dly), .echo(ECHO));
  initial forever #50 CLK = ~CLK;
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'h1) begin
      fail_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk
  task automatic tally_and_finish(input int lost);
    fail_count += lost;
    $display("compared %0d bad %0d open fault %0.1f m", n_compared, fail_count, far_m);
    if (fail_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  // bounded wait; running out ends the run as a failure
  task automatic wait_hi(ref logic s, input int lim);
    repeat (lim) if (s !== 1'h1) @(negedge CLK);
    if (s !== 1'h1) tally_and_finish(1);
  endtask : wait_hi
  // a new result is held against the oldest note; lengths must track the echo delay
  always @(negedge CLK) begin
    seen <= TDR_DONE;
    if (TDR_DONE === 1'h1 && seen !== 1'h1) begin
      d = notes.pop_front();
      if (d == 0)
        chk(CHANNEL_LENGTH === '1, "echo on matched line");
      else if (last_d != 0)
        chk(CHANNEL_LENGTH === last_len + LEN_W'(d - last_d), "length");
      if (d != 0) begin
        last_d = d;
        last_len = CHANNEL_LENGTH;
        far_m = real'(CHANNEL_LENGTH) * 0.769;
      end
    end
  end
  // stimulus, all changes at the falling edge
  initial begin
    void'($urandom(39));
    repeat (5) @(negedge CLK);
    RESET_N = 1;
    DATA_VALID = 1;
    repeat (15) @(negedge CLK);
    DATA_VALID = 0;
    repeat (3) @(negedge CLK);
    DATA_VALID = 1;
    repeat (15) @(negedge CLK);
    chk(LINK_STATUS === 1'h0, "count not restarted");
    wait_hi(LINK_STATUS, 20);
    chk(TXRX_ENABLE === 1'h1, "datapath off");
    DATA_VALID = 0;
    repeat (4) @(negedge CLK);
    chk(LINK_STATUS === 1'h0, "link kept");
    ANEG_EN = 1;
    DATA_VALID = 1;
    repeat (40) @(negedge CLK);
    chk(LINK_STATUS === 1'h0, "up before negotiation");
    ANEG_DONE = 1;
    wait_hi(LINK_STATUS, 4);
    SPEED_10 = 1;
    repeat (4) begin
      LINK_10 = 1'($urandom);
      @(negedge CLK);
      chk(LINK_STATUS === LINK_10, "10M link ignored");
    end
    SPEED_10 = 0;
    ANEG_EN = 0;
    // alternate pairs; a zero delay is a matched line that never echoes
    for (int i = 0; i < 6; i++) begin
      CROSSOVER_STATE_SELECT = i[0];
      dly = i == 5 ? 0 : 1 + $urandom % 100;
      notes.push_back(dly);
      TDR_EN = 1;
      wait_hi(TDR_DONE, 400);
      TDR_EN = 0;
      @(negedge CLK);
    end
    ANEG_EN = 1;
    FX_MODE = 1;
    TDR_EN = 1;
    repeat (20) @(negedge CLK);
    chk(TDR_DONE === 1'h0, "test in fiber");
    TDR_EN = 0;
    FX_MODE = 0;
    POWER_DOWN = 1;
    repeat (5) @(negedge CLK);
    POWER_DOWN = 0;
    wait_hi(PHY_LOGIC_RST, 6);
    repeat (20) @(negedge CLK);
    chk(PHY_LOGIC_RST === 1'h0, "reset stuck");
    chk(CHANNEL_LENGTH === '1, "result lost on wake");
    tally_and_finish(0);
  end
endmodule : plm_top_tb
